// ### verilog/sesg_pkg.sv
// Function
// - Serial two bits 0-6 are board errors, no condition readback.
// - Record board errors only at power-up or self-test.
// - Serial two summary heads toward status bit zero.
// - Status reaches byte only through both enabled summaries.
// - Event register clears on query or clear-status.
// - Enable register keeps written value of used bits only; unused bits read back zero.
// - Separate readable positive and negative transition filters.
// - Serial two bits 7-15 never set.
// - Standard event bits 10-15 always read zero.
// - Summary is one when an enabled event is latched.
package sesg_pkg;
	localparam int SESG_W = 16;
	localparam logic [SESG_W-1:0] SESG_GRP2_USED_MASK = 16'h007F;
	localparam logic [SESG_W-1:0] SESG_GRP1_USED_MASK = 16'h01FF;
	localparam logic [SESG_W-1:0] SESG_STD_USED_MASK  = 16'h03FF;
	localparam logic [SESG_W-1:0] SESG_PTR_RESET      = 16'hFFFF;
	localparam logic [SESG_W-1:0] SESG_NTR_RESET      = 16'h0000;
	localparam logic [SESG_W-1:0] SESG_ENAB_RESET     = 16'h0000;
	localparam int SESG_SEL_W = 4;

	// Register selectors used by the status command decoder.
	typedef enum logic [3:0] {
		SESG_SEL_S1_EVENT,
		SESG_SEL_S1_ENABLE,
		SESG_SEL_S1_PTR,
		SESG_SEL_S1_NTR,
		SESG_SEL_S2_EVENT,
		SESG_SEL_S2_ENABLE,
		SESG_SEL_S2_PTR,
		SESG_SEL_S2_NTR,
		SESG_SEL_S2_COND,
		SESG_SEL_STD_EVENT,
		SESG_SEL_STD_ENABLE,
		SESG_SEL_COMM_ENABLE,
		SESG_SEL_HW1_ENABLE
	} sesg_sel_t;
endpackage : sesg_pkg

// ### verilog/sesg_event_group.sv
`timescale 1ns/100ps
// One status group: transition filters, sticky event latch, enable mask and summary.
module sesg_event_group #(
	parameter int W = 16,
	parameter logic [W-1:0] USED = '1,
	parameter logic [W-1:0] PTR_RST = '1,
	parameter logic [W-1:0] NTR_RST = '0
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	// Condition inputs and capture gate
	input  wire logic [W-1:0] i_cond,
	input  wire logic         i_capture_en,
	// Register access
	input  wire logic [W-1:0] i_wdata,
	input  wire logic         i_wr_ptr,
	input  wire logic         i_wr_ntr,
	input  wire logic         i_wr_enable,
	input  wire logic         i_event_clear,
	// State
	output logic      [W-1:0] o_event,
	output logic      [W-1:0] o_enable,
	output logic      [W-1:0] o_ptr,
	output logic      [W-1:0] o_ntr,
	output logic              o_summary
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0] event_q;
		logic [W-1:0] enable;
		logic [W-1:0] ptr;
		logic [W-1:0] ntr;
	} sesg_grp_t;

	sesg_grp_t st;
	sesg_grp_t next_st;
	logic [W-1:0] hit;

	always_comb begin
		next_st = st;
		hit = ((i_cond & ~st.prev & st.ptr) | (~i_cond & st.prev & st.ntr)) & USED;
		if (!i_capture_en) begin
			hit = '0;
		end
		next_st.prev = i_cond & USED;
		if (i_event_clear) begin
			next_st.event_q = hit;
		end else begin
			next_st.event_q = st.event_q | hit;
		end
		if (i_wr_enable) begin
			next_st.enable = i_wdata & USED;
		end
		if (i_wr_ptr) begin
			next_st.ptr = i_wdata & USED;
		end
		if (i_wr_ntr) begin
			next_st.ntr = i_wdata & USED;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st.prev    <= '0;
			st.event_q <= '0;
			st.enable  <= '0;
			st.ptr     <= PTR_RST & USED;
			st.ntr     <= NTR_RST & USED;
		end else begin
			st <= next_st;
		end
	end

	assign o_event   = st.event_q;
	assign o_enable  = st.enable;
	assign o_ptr     = st.ptr;
	assign o_ntr     = st.ntr;
	assign o_summary = |(st.event_q & st.enable);
endmodule : sesg_event_group

// ### verilog/sesg_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of pin levels.
module sesg_sync #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst,
	// Levels
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sesg_sync_t;

	sesg_sync_t st;
	sesg_sync_t next_st;

	always_comb begin
		next_st.s1 = i_async;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_sync = st.s2;
endmodule : sesg_sync

// ### verilog/sesg_status_top.sv
`timescale 1ns/100ps
// Serial error status groups with their path toward status byte bit zero.
module sesg_status_top #(
	parameter int W = sesg_pkg::SESG_W
) (
	// Clock and reset
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst,
	// Board error levels from the serial receiver chips
	input  wire logic [W-1:0]              i_grp1_err,
	input  wire logic [W-1:0]              i_grp2_err,
	// Standard event sources, one-cycle pulses
	input  wire logic [W-1:0]              i_std_event,
	// Test phases
	input  wire logic                      i_power_up_active,
	input  wire logic                      i_self_test_active,
	input  wire logic                      i_clear_status,
	// Status command port
	input  wire logic                      i_cmd_valid,
	input  wire logic                      i_cmd_write,
	input  wire logic [sesg_pkg::SESG_SEL_W-1:0] i_cmd_sel,
	input  wire logic [W-1:0]              i_cmd_wdata,
	output logic                           o_rsp_valid,
	output logic      [W-1:0]              o_rsp_data,
	// Summaries
	output logic                           o_grp1_summary,
	output logic                           o_grp2_summary,
	output logic                           o_comm_summary,
	output logic                           o_hw1_summary,
	output logic                           o_stb_bit0,
	output logic                           o_std_summary
);
	import sesg_pkg::*;

	typedef struct packed {
		logic         rsp_valid;
		logic [W-1:0] rsp_data;
		logic [W-1:0] std_event;
		logic [W-1:0] std_enable;
		logic [1:0]   comm_enable;
		logic         hw1_enable;
		logic         grp1_sum;
		logic         grp2_sum;
		logic         comm_sum;
		logic         hw1_sum;
		logic         stb0;
		logic         std_sum;
	} sesg_top_t;

	sesg_top_t st;
	sesg_top_t next_st;

	logic [W-1:0] s1_sync;
	logic [W-1:0] s2_sync;
	logic [W-1:0] s1_event, s1_enable, s1_ptr, s1_ntr;
	logic [W-1:0] s2_event, s2_enable, s2_ptr, s2_ntr;
	logic         s1_sum, s2_sum;
	logic         capture_en;
	logic         wr, rd;
	logic         s1_clr, s2_clr;

	function automatic logic sel_is(input logic [SESG_SEL_W-1:0] sel, input sesg_sel_t which);
		sel_is = (sel == SESG_SEL_W'(which));
	endfunction : sel_is

	assign wr         = i_cmd_valid && i_cmd_write;
	assign rd         = i_cmd_valid && !i_cmd_write;
	assign capture_en = i_power_up_active || i_self_test_active;
	assign s1_clr     = i_clear_status || (rd && sel_is(i_cmd_sel, SESG_SEL_S1_EVENT));
	assign s2_clr     = i_clear_status || (rd && sel_is(i_cmd_sel, SESG_SEL_S2_EVENT));

	sesg_sync #(.W(W)) u_sync1 (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_grp1_err),
		.o_sync    (s1_sync)
	);

	sesg_sync #(.W(W)) u_sync2 (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_async   (i_grp2_err),
		.o_sync    (s2_sync)
	);

	sesg_event_group #(
		.W       (W),
		.USED    (SESG_GRP1_USED_MASK),
		.PTR_RST (SESG_PTR_RESET),
		.NTR_RST (SESG_NTR_RESET)
	) u_first_serial_error_group (
		.i_sys_clk     (i_sys_clk),
		.i_rst         (i_rst),
		.i_cond        (s1_sync),
		.i_capture_en  (capture_en),
		.i_wdata       (i_cmd_wdata),
		.i_wr_ptr      (wr && sel_is(i_cmd_sel, SESG_SEL_S1_PTR)),
		.i_wr_ntr      (wr && sel_is(i_cmd_sel, SESG_SEL_S1_NTR)),
		.i_wr_enable   (wr && sel_is(i_cmd_sel, SESG_SEL_S1_ENABLE)),
		.i_event_clear (s1_clr),
		.o_event       (s1_event),
		.o_enable      (s1_enable),
		.o_ptr         (s1_ptr),
		.o_ntr         (s1_ntr),
		.o_summary     (s1_sum)
	);

	// Bits 0 to 6 only; reserved and unused bits are masked off inside the group.
	sesg_event_group #(
		.W       (W),
		.USED    (SESG_GRP2_USED_MASK),
		.PTR_RST (SESG_PTR_RESET),
		.NTR_RST (SESG_NTR_RESET)
	) u_second_serial_error_group (
		.i_sys_clk     (i_sys_clk),
		.i_rst         (i_rst),
		.i_cond        (s2_sync),
		.i_capture_en  (capture_en),
		.i_wdata       (i_cmd_wdata),
		.i_wr_ptr      (wr && sel_is(i_cmd_sel, SESG_SEL_S2_PTR)),
		.i_wr_ntr      (wr && sel_is(i_cmd_sel, SESG_SEL_S2_NTR)),
		.i_wr_enable   (wr && sel_is(i_cmd_sel, SESG_SEL_S2_ENABLE)),
		.i_event_clear (s2_clr),
		.o_event       (s2_event),
		.o_enable      (s2_enable),
		.o_ptr         (s2_ptr),
		.o_ntr         (s2_ntr),
		.o_summary     (s2_sum)
	);

	always_comb begin
		next_st = st;
		next_st.rsp_valid = rd;
		next_st.rsp_data  = '0;
		if (rd) begin
			unique case (i_cmd_sel)
				SESG_SEL_W'(SESG_SEL_S1_EVENT):    next_st.rsp_data = s1_event;
				SESG_SEL_W'(SESG_SEL_S1_ENABLE):   next_st.rsp_data = s1_enable;
				SESG_SEL_W'(SESG_SEL_S1_PTR):      next_st.rsp_data = s1_ptr;
				SESG_SEL_W'(SESG_SEL_S1_NTR):      next_st.rsp_data = s1_ntr;
				SESG_SEL_W'(SESG_SEL_S2_EVENT):    next_st.rsp_data = s2_event;
				SESG_SEL_W'(SESG_SEL_S2_ENABLE):   next_st.rsp_data = s2_enable;
				SESG_SEL_W'(SESG_SEL_S2_PTR):      next_st.rsp_data = s2_ptr;
				SESG_SEL_W'(SESG_SEL_S2_NTR):      next_st.rsp_data = s2_ntr;
				// No condition register exists for these board errors, so it reads zero.
				SESG_SEL_W'(SESG_SEL_S2_COND):     next_st.rsp_data = '0;
				SESG_SEL_W'(SESG_SEL_STD_EVENT):   next_st.rsp_data = st.std_event & SESG_STD_USED_MASK;
				SESG_SEL_W'(SESG_SEL_STD_ENABLE):  next_st.rsp_data = st.std_enable;
				SESG_SEL_W'(SESG_SEL_COMM_ENABLE): next_st.rsp_data = W'(st.comm_enable);
				SESG_SEL_W'(SESG_SEL_HW1_ENABLE):  next_st.rsp_data = W'(st.hw1_enable);
				default:                           next_st.rsp_data = '0;
			endcase
		end
		// A source pulse in the same cycle as a clear is kept.
		if (i_clear_status || (rd && sel_is(i_cmd_sel, SESG_SEL_STD_EVENT))) begin
			next_st.std_event = i_std_event & SESG_STD_USED_MASK;
		end else begin
			next_st.std_event = (st.std_event | i_std_event) & SESG_STD_USED_MASK;
		end
		if (wr && sel_is(i_cmd_sel, SESG_SEL_STD_ENABLE)) begin
			next_st.std_enable = i_cmd_wdata & SESG_STD_USED_MASK;
		end
		if (wr && sel_is(i_cmd_sel, SESG_SEL_COMM_ENABLE)) begin
			next_st.comm_enable = i_cmd_wdata[1:0];
		end
		if (wr && sel_is(i_cmd_sel, SESG_SEL_HW1_ENABLE)) begin
			next_st.hw1_enable = i_cmd_wdata[0];
		end
		next_st.grp1_sum = s1_sum;
		next_st.grp2_sum = s2_sum;
		// Summaries chain from the serial groups through communication and hardware one.
		next_st.comm_sum = |({s2_sum, s1_sum} & st.comm_enable);
		next_st.hw1_sum  = next_st.comm_sum && st.hw1_enable;
		next_st.stb0     = next_st.hw1_sum;
		next_st.std_sum  = |(st.std_event & st.std_enable);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rsp_valid    = st.rsp_valid;
	assign o_rsp_data     = st.rsp_data;
	assign o_grp1_summary = st.grp1_sum;
	assign o_grp2_summary = st.grp2_sum;
	assign o_comm_summary = st.comm_sum;
	assign o_hw1_summary  = st.hw1_sum;
	assign o_stb_bit0     = st.stb0;
	assign o_std_summary  = st.std_sum;
endmodule : sesg_status_top

// ### tb/sesg_status_sva.sv
`timescale 1ns/100ps
// Port-level checks of the status command answer and the summary chain.
module sesg_status_sva #(
	parameter int W = sesg_pkg::SESG_W
) (
	input wire logic                  i_sys_clk,
	input wire logic                  i_rst,
	input wire logic                  i_cmd_valid,
	input wire logic                  i_cmd_write,
	input wire logic [sesg_pkg::SESG_SEL_W-1:0] i_cmd_sel,
	input wire logic                  o_rsp_valid,
	input wire logic [W-1:0]          o_rsp_data,
	input wire logic                  o_grp1_summary,
	input wire logic                  o_grp2_summary,
	input wire logic                  o_comm_summary,
	input wire logic                  o_hw1_summary,
	input wire logic                  o_stb_bit0
);
	import sesg_pkg::*;
	logic rd;
	assign rd = i_cmd_valid && !i_cmd_write;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	chk_read_answer: assert property (rd |=> o_rsp_valid) else $error("read got no answer");
	chk_write_silent: assert property (i_cmd_valid && i_cmd_write |=> !o_rsp_valid) else $error("write answered");
	chk_idle_data: assert property (!o_rsp_valid |-> o_rsp_data == '0) else $error("data without answer");
	chk_cond_none: assert property (rd && i_cmd_sel == 4'h8 |=> o_rsp_data == '0) else $error("condition read");
	chk_second_serial_error_group_unused: assert property (rd && i_cmd_sel == 4'h4 |=> o_rsp_data[15:7] == '0) else $error("bits set");
	chk_std_reserved: assert property (rd && i_cmd_sel == 4'h9 |=> o_rsp_data[15:10] == '0) else $error("std bits");
	chk_stb_route: assert property (o_stb_bit0 == o_hw1_summary) else $error("status bit zero route");
	chk_hw1_gate: assert property (o_hw1_summary |-> o_comm_summary) else $error("hw1 without comm");
	chk_comm_gate: assert property (o_comm_summary |-> o_grp1_summary || o_grp2_summary) else $error("comm alone");
endmodule : sesg_status_sva

bind sesg_status_top sesg_status_sva #(.W(W)) u_sva (.i_sys_clk, .i_rst, .i_cmd_valid, .i_cmd_write, .i_cmd_sel,
	.o_rsp_valid, .o_rsp_data, .o_grp1_summary, .o_grp2_summary, .o_comm_summary, .o_hw1_summary, .o_stb_bit0);

// ### tb/sesg_ctrl_model.sv
`timescale 1ns/100ps
// Remote controller: one status command at a time, launched just after an edge.
module sesg_ctrl_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rsp_valid,
	input  wire logic [15:0] i_rsp_data,
	output logic             o_cmd_valid,
	output logic             o_cmd_write,
	output logic [3:0]       o_cmd_sel,
	output logic [15:0]      o_cmd_wdata
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_write = 1'b0;
		o_cmd_sel = 4'hF;
		o_cmd_wdata = 16'h0000;
	end
	// Released select and data lines are inverted so a stale value can never pass as fresh.
	task automatic send(input logic w, input logic [3:0] s, input logic [15:0] d);
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b1;
		o_cmd_write <= w;
		o_cmd_sel <= s;
		o_cmd_wdata <= d;
		@(posedge i_sys_clk);
		o_cmd_valid <= 1'b0;
		o_cmd_sel <= ~s;
		o_cmd_wdata <= ~d;
	endtask : send
	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		send(1'b1, s, d);
	endtask : wr
	task automatic rd(input logic [3:0] s, output logic [15:0] d, output logic v);
		send(1'b0, s, 16'h0000);
		#1;
		v = i_rsp_valid;
		d = i_rsp_data;
	endtask : rd
endmodule : sesg_ctrl_model

// ### tb/serial_error_status_groups_bench.sv
`timescale 1ns/100ps
module serial_error_status_groups_bench;
	import sesg_pkg::*;
	logic        i_sys_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [15:0] i_grp1_err, i_grp2_err, i_std_event, i_cmd_wdata, o_rsp_data, rv;
	logic [3:0]  i_cmd_sel;
	logic        i_power_up_active, i_self_test_active, i_clear_status, i_cmd_valid, i_cmd_write, o_rsp_valid, ok;
	logic        o_grp1_summary, o_grp2_summary, o_comm_summary, o_hw1_summary, o_stb_bit0, o_std_summary;
	int          bad_count = 0;
	int          compares = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	sesg_status_top uut (.i_sys_clk, .i_rst, .i_grp1_err, .i_grp2_err, .i_std_event, .i_power_up_active,
		.i_self_test_active, .i_clear_status, .i_cmd_valid, .i_cmd_write, .i_cmd_sel, .i_cmd_wdata, .o_rsp_valid,
		.o_rsp_data, .o_grp1_summary, .o_grp2_summary, .o_comm_summary, .o_hw1_summary, .o_stb_bit0, .o_std_summary);
	sesg_ctrl_model ctrl (.i_sys_clk, .i_rsp_valid(o_rsp_valid), .i_rsp_data(o_rsp_data), .o_cmd_valid(i_cmd_valid),
		.o_cmd_write(i_cmd_write), .o_cmd_sel(i_cmd_sel), .o_cmd_wdata(i_cmd_wdata));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdchk(input logic [3:0] s, input logic [15:0] e, input string n);
		ctrl.rd(s, rv, ok);
		chk("rsp_valid", 16'h0001, {15'h0000, ok});
		chk(n, e, rv);
	endtask : rdchk
	task automatic wait_n(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : wait_n
	task automatic t_registers;
		rdchk(SESG_SEL_S2_ENABLE, 16'h0000, "s2 enable");
		rdchk(SESG_SEL_S2_PTR, 16'h007F, "s2 ptr");
		rdchk(SESG_SEL_S2_NTR, 16'h0000, "s2 ntr");
		ctrl.wr(SESG_SEL_S2_ENABLE, 16'h0055);
		rdchk(SESG_SEL_S2_ENABLE, 16'h0055, "s2 enable");
		ctrl.wr(SESG_SEL_S2_ENABLE, 16'h007F);
		ctrl.wr(SESG_SEL_S2_PTR, 16'h0005);
		ctrl.wr(SESG_SEL_S2_NTR, 16'h0002);
		rdchk(SESG_SEL_S2_PTR, 16'h0005, "s2 ptr");
		rdchk(SESG_SEL_S2_NTR, 16'h0002, "s2 ntr");
		rdchk(SESG_SEL_S2_COND, 16'h0000, "s2 cond");
		ctrl.wr(SESG_SEL_COMM_ENABLE, 16'h0002);
		ctrl.wr(SESG_SEL_HW1_ENABLE, 16'h0001);
	endtask : t_registers
	task automatic t_capture;
		@(posedge i_sys_clk) i_power_up_active <= 1'b1;
		@(posedge i_sys_clk) i_grp2_err <= 16'h0083;
		i_grp1_err <= 16'h0100;
		wait_n(6);
		chk("stb_bit0", 16'h0001, {15'h0000, o_stb_bit0});
		chk("grp1_summary", 16'h0000, {15'h0000, o_grp1_summary});
		rdchk(SESG_SEL_S1_EVENT, 16'h0100, "s1 event");
		rdchk(SESG_SEL_S2_EVENT, 16'h0001, "s2 event");
		rdchk(SESG_SEL_S2_EVENT, 16'h0000, "s2 event");
		@(posedge i_sys_clk) i_grp2_err <= 16'h0000;
		wait_n(6);
		rdchk(SESG_SEL_S2_EVENT, 16'h0002, "s2 event");
		@(posedge i_sys_clk) i_power_up_active <= 1'b0;
	endtask : t_capture
	task automatic t_gating;
		@(posedge i_sys_clk) i_self_test_active <= 1'b1;
		@(posedge i_sys_clk) i_grp2_err <= 16'h0004;
		wait_n(6);
		ctrl.wr(SESG_SEL_COMM_ENABLE, 16'h0000);
		wait_n(2);
		chk("stb_bit0", 16'h0000, {15'h0000, o_stb_bit0});
		chk("grp2_summary", 16'h0001, {15'h0000, o_grp2_summary});
		ctrl.wr(SESG_SEL_COMM_ENABLE, 16'h0002);
		ctrl.wr(SESG_SEL_HW1_ENABLE, 16'h0000);
		wait_n(2);
		chk("stb_bit0", 16'h0000, {15'h0000, o_stb_bit0});
		chk("comm_summary", 16'h0001, {15'h0000, o_comm_summary});
		ctrl.wr(SESG_SEL_HW1_ENABLE, 16'h0001);
		ctrl.wr(SESG_SEL_S2_ENABLE, 16'h0003);
		wait_n(2);
		chk("grp2_summary", 16'h0000, {15'h0000, o_grp2_summary});
		ctrl.wr(SESG_SEL_S2_ENABLE, 16'h007F);
		wait_n(2);
		chk("stb_bit0", 16'h0001, {15'h0000, o_stb_bit0});
		@(posedge i_sys_clk) i_clear_status <= 1'b1;
		@(posedge i_sys_clk) i_clear_status <= 1'b0;
		i_self_test_active <= 1'b0;
		i_grp2_err <= 16'h0000;
		wait_n(2);
		chk("grp2_summary", 16'h0000, {15'h0000, o_grp2_summary});
		rdchk(SESG_SEL_S2_EVENT, 16'h0000, "s2 event");
	endtask : t_gating
	task automatic t_idle_and_std;
		@(posedge i_sys_clk) i_grp2_err <= 16'h0004;
		wait_n(6);
		rdchk(SESG_SEL_S2_EVENT, 16'h0000, "s2 event");
		ctrl.wr(SESG_SEL_STD_ENABLE, 16'hFFFF);
		@(posedge i_sys_clk) i_std_event <= 16'hFFFF;
		@(posedge i_sys_clk) i_std_event <= 16'h0000;
		wait_n(2);
		chk("std_summary", 16'h0001, {15'h0000, o_std_summary});
		rdchk(SESG_SEL_STD_EVENT, 16'h03FF, "std event");
	endtask : t_idle_and_std
	task automatic report_and_stop;
		if (bad_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// The first group's pins raise only bit 8; both groups share the same filter and latch logic.
	initial begin
		i_grp1_err = 16'h0000;
		i_grp2_err = 16'h0000;
		i_std_event = 16'h0000;
		i_power_up_active = 1'b0;
		i_self_test_active = 1'b0;
		i_clear_status = 1'b0;
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		t_registers();
		t_capture();
		t_gating();
		t_idle_and_std();
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge i_sys_clk);
		bad_count++;
		report_and_stop();
	end
endmodule : serial_error_status_groups_bench
